// file: shared/frame_pkg.sv
// Purpose: Shared constants for the distance report framer and its receiver
// Assumes: Byte-wide link with valid and ready, one clock domain
// Notes: Checksum is the reflected 16-bit form of x^16+x^15+x^2+1

package frame_pkg;

    // ==========================================================
    // Framing symbols
    localparam logic [7:0] SOF_BYTE = 8'h7E;
    localparam logic [7:0] EOF_BYTE = 8'h7F;
    localparam logic [7:0] ESC_BYTE = 8'h7D;
    localparam logic [7:0] ESC_XOR = 8'h20;
    localparam logic [7:0] TYPE_DIST = 8'h00;

    // ==========================================================
    // Packet layout (unstuffed): type + 16 data bytes, then checksum
    localparam logic [4:0] BODY_LEN = 5'h11;
    localparam logic [4:0] LAST_IDX = 5'h12;
    localparam logic [4:0] RX_LEN = 5'h13;
    localparam logic [4:0] RX_OVER = 5'h14;
    localparam logic [4:0] PKT_LEN = 5'h15;
    localparam logic [7:0] SPECIAL_LO = 8'h7D;
    localparam logic [7:0] SPECIAL_HI = 8'h7F;

    // Field positions inside the 19-byte receive shift register
    localparam int F_TYPE = 144;
    localparam int F_SRC = 128;
    localparam int F_DST = 112;
    localparam int F_ANT = 104;
    localparam int F_DIST = 72;
    localparam int F_VEL = 40;
    localparam int F_LVL = 32;
    localparam int F_ERR = 24;
    localparam int F_STAT = 16;
    localparam int F_CRC = 0;

    // ==========================================================
    // Checksum
    localparam logic [15:0] CRC_POLY_REFL = 16'hA001;
    localparam logic [15:0] CRC_INIT = 16'h0000;

    // ==========================================================
    // Error and range codes
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] STAT_INSIDE = 8'h00;
    localparam logic [7:0] STAT_OUTSIDE = 8'h01;
    localparam logic [31:0] RANGE_120M_MM = 32'h0001_D4C0;
    localparam logic [31:0] RANGE_500M_MM = 32'h0007_A120;

    // ==========================================================
    // Receiver registers (APB byte offsets)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_SRC = 8'h0C;
    localparam logic [7:0] OFS_DST = 8'h10;
    localparam logic [7:0] OFS_DIST = 8'h14;
    localparam logic [7:0] OFS_VEL = 8'h18;
    localparam logic [7:0] OFS_MISC = 8'h1C;
    localparam logic [7:0] OFS_LEVEL = 8'h20;
    localparam logic [7:0] OFS_ADDR_INFO = 8'h24;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [4:0] MASK_RESET = 5'h00;

    // Event bits of status and mask
    localparam int EV_OK = 0;
    localparam int EV_CRC = 1;
    localparam int EV_LEN = 2;
    localparam int EV_ABORT = 3;
    localparam int EV_MEAS = 4;

    // One checksum step over one original byte
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY_REFL) : (r >> 1);
        end
        return r;
    endfunction

endpackage

// file: shared/frame_link_if.sv
// Purpose: Byte link between the framer and the receiving controller
// Assumes: A byte moves on a clock edge where valid, ready and clk_en are all high
// Notes: No clocking block; the bench joins both ends

`timescale 1ns/100ps

interface frame_link_if;
    logic [7:0] data;
    logic valid;
    logic ready;

    modport dev (output data, output valid, input ready);
    modport host (input data, input valid, output ready);
endinterface : frame_link_if

// file: rtl/distance_report_framer.sv
// Purpose: Builds and sends one stuffed distance report per request
// Assumes: ref_clk at 200 MHz, rst_n asynchronous active low
// Notes: Request is taken while req_ready is high; one packet at a time

`timescale 1ns/100ps

module distance_report_framer #(
    parameter logic [31:0] MAX_RANGE_MM = frame_pkg::RANGE_120M_MM
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [4:0] own_station,
    input wire logic [9:0] own_group,
    input wire logic [4:0] peer_station,
    input wire logic [9:0] peer_group,
    input wire logic [3:0] base_port,
    input wire logic [3:0] peer_port,
    input wire logic signed [31:0] distance,
    input wire logic signed [31:0] velocity,
    input wire logic [7:0] level,
    input wire logic [6:0] fault,
    frame_link_if.dev link
);

    // ==========================================================
    // State and storage
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_SOF = 5'h02,
        S_BODY = 5'h04,
        S_ESC = 5'h08,
        S_EOF = 5'h10
    } tx_state_t;

    tx_state_t state_ff;
    logic [135:0] body_ff;
    logic [15:0] crc_ff;
    logic [4:0] idx_ff;
    logic [7:0] byte_ff;
    logic valid_ff;
    logic ready_ff;
    logic take;
    logic xfer;
    logic out_of_range;
    logic signed [31:0] dist_rep;
    logic [7:0] fault_code;
    logic [15:0] src_addr;
    logic [15:0] dst_addr;
    logic [4:0] nxt_idx;
    logic [4:0] look_idx;
    logic [7:0] cur_byte;
    logic [7:0] look_byte;
    logic [15:0] nxt_crc;
    logic [15:0] look_crc;

    assign req_ready = ready_ff;
    assign link.data = byte_ff;
    assign link.valid = valid_ff;
    assign take = clk_en && req_valid && ready_ff;
    assign xfer = clk_en && valid_ff && link.ready;

    // Byte of the unstuffed sequence: body first, checksum last
    function automatic logic [7:0] byte_at(input logic [4:0] i, input logic [15:0] c);
        logic [7:0] b;
        b = c[7:0];
        if (i < frame_pkg::BODY_LEN) begin
            b = body_ff[(16 - i) * 8 +: 8];
        end else if (i == frame_pkg::BODY_LEN) begin
            b = c[15:8];
        end
        return b;
    endfunction

    function automatic logic needs_esc(input logic [7:0] b);
        return (b >= frame_pkg::SPECIAL_LO) && (b <= frame_pkg::SPECIAL_HI);
    endfunction

    // ==========================================================
    // Field preparation
    // Distance saturation
    always_comb begin
        out_of_range = distance > $signed(MAX_RANGE_MM);
        dist_rep = out_of_range ? $signed(MAX_RANGE_MM) : distance;
    end

    always_comb begin
        fault_code = frame_pkg::ERR_NONE;
        for (int k = 6; k >= 0; k--) begin
            if (fault[k]) begin
                fault_code = 8'(k + 1);
            end
        end
    end

    always_comb begin
        src_addr = {own_station, own_group, 1'b1};
        dst_addr = {peer_station, peer_group, 1'b0};
    end

    // ==========================================================
    // Capture of one report
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            body_ff <= '0;
        end else if (take) begin
            body_ff <= {frame_pkg::TYPE_DIST, src_addr, dst_addr, base_port, peer_port,
                        dist_rep, velocity, level, fault_code,
                        out_of_range ? frame_pkg::STAT_OUTSIDE : frame_pkg::STAT_INSIDE};
        end
    end

    // ==========================================================
    // Look-ahead of the next byte
    always_comb begin
        nxt_idx = idx_ff + 5'h01;
        cur_byte = byte_at(idx_ff, crc_ff);
        nxt_crc = (idx_ff < frame_pkg::BODY_LEN) ? frame_pkg::crc_step(crc_ff, cur_byte)
                                                  : crc_ff;
        look_idx = (state_ff == S_SOF) ? idx_ff : nxt_idx;
        look_crc = (state_ff == S_SOF) ? crc_ff : nxt_crc;
        look_byte = byte_at(look_idx, look_crc);
    end

    // ==========================================================
    // Checksum
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_ff <= frame_pkg::CRC_INIT;
        end else if (take) begin
            crc_ff <= frame_pkg::CRC_INIT;
        end else if (xfer && state_ff == S_BODY) begin
            crc_ff <= nxt_crc;
        end
    end

    // ==========================================================
    // Sender sequence
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= S_IDLE;
            idx_ff <= 5'h00;
            byte_ff <= 8'h00;
            valid_ff <= 1'b0;
            ready_ff <= 1'b0;
        end else if (clk_en) begin
            case (state_ff)
                S_IDLE: begin
                    ready_ff <= 1'b1;
                    if (take) begin
                        ready_ff <= 1'b0;
                        idx_ff <= 5'h00;
                        byte_ff <= frame_pkg::SOF_BYTE;
                        valid_ff <= 1'b1;
                        state_ff <= S_SOF;
                    end
                end
                S_SOF, S_BODY: begin
                    if (xfer) begin
                        if (state_ff == S_BODY && idx_ff == frame_pkg::LAST_IDX) begin
                            byte_ff <= frame_pkg::EOF_BYTE;
                            state_ff <= S_EOF;
                        end else if (needs_esc(look_byte)) begin
                            idx_ff <= look_idx;
                            byte_ff <= frame_pkg::ESC_BYTE;
                            state_ff <= S_ESC;
                        end else begin
                            idx_ff <= look_idx;
                            byte_ff <= look_byte;
                            state_ff <= S_BODY;
                        end
                    end
                end
                S_ESC: begin
                    if (xfer) begin
                        byte_ff <= cur_byte ^ frame_pkg::ESC_XOR;
                        state_ff <= S_BODY;
                    end
                end
                S_EOF: begin
                    if (xfer) begin
                        valid_ff <= 1'b0;
                        state_ff <= S_IDLE;
                    end
                end
                default: begin
                    valid_ff <= 1'b0;
                    ready_ff <= 1'b0;
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    // Level sent raw as two's complement

endmodule // distance_report_framer

// file: rtl/distance_report_receiver.sv
// Purpose: Unstuffs, checks and stores distance reports for software
// Assumes: ref_clk at 200 MHz, rst_n asynchronous active low, APB slave
// Notes: One level interrupt from sticky write-one-to-clear status
//
// The implementer's own choices: the APB register port and the register offsets.

`timescale 1ns/100ps

module distance_report_receiver (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    frame_link_if.host link
);

    // ==========================================================
    // State and storage
    typedef enum logic [2:0] {
        R_HUNT = 3'h1,
        R_BODY = 3'h2,
        R_ESC = 3'h4
    } rx_state_t;

    rx_state_t state_ff;
    logic [151:0] shift_ff;
    logic [4:0] cnt_ff;
    logic [15:0] crc_ff;
    logic rdy_ff;
    logic [4:0] ev;
    logic [4:0] stat_ff;
    logic [4:0] mask_ff;
    logic [31:0] ctrl_ff;
    logic [15:0] src_ff;
    logic [15:0] dst_ff;
    logic [31:0] dist_ff;
    logic [31:0] vel_ff;
    logic [31:0] misc_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_ff;
    logic take;
    logic [7:0] orig;
    logic apb_setup;
    logic apb_wr;
    logic [31:0] rd_mux;
    logic rd_hit;

    assign link.ready = rdy_ff;
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign take = clk_en && link.valid && rdy_ff;
    assign orig = (state_ff == R_ESC) ? (link.data ^ frame_pkg::ESC_XOR) : link.data;

    // ==========================================================
    // Unstuffing and checking
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= R_HUNT;
            cnt_ff <= 5'h00;
            crc_ff <= frame_pkg::CRC_INIT;
            shift_ff <= '0;
            ev <= 5'h00;
        end else if (clk_en) begin
            ev <= 5'h00;
            if (take) begin
                if (link.data == frame_pkg::SOF_BYTE) begin
                    ev[frame_pkg::EV_ABORT] <= (state_ff != R_HUNT);
                    state_ff <= R_BODY;
                    cnt_ff <= 5'h00;
                    crc_ff <= frame_pkg::CRC_INIT;
                end else if (state_ff == R_HUNT) begin
                    state_ff <= R_HUNT;
                end else if (link.data == frame_pkg::EOF_BYTE) begin
                    state_ff <= R_HUNT;
                    if (cnt_ff != frame_pkg::RX_LEN || state_ff == R_ESC ||
                        shift_ff[frame_pkg::F_TYPE +: 8] != frame_pkg::TYPE_DIST) begin
                        ev[frame_pkg::EV_LEN] <= 1'b1;
                    end else if (crc_ff != shift_ff[frame_pkg::F_CRC +: 16]) begin
                        ev[frame_pkg::EV_CRC] <= 1'b1;
                    end else begin
                        ev[frame_pkg::EV_OK] <= 1'b1;
                        ev[frame_pkg::EV_MEAS] <=
                            shift_ff[frame_pkg::F_ERR +: 8] != frame_pkg::ERR_NONE;
                    end
                end else if (link.data == frame_pkg::ESC_BYTE && state_ff == R_BODY) begin
                    state_ff <= R_ESC;
                end else begin
                    state_ff <= R_BODY;
                    if (cnt_ff < frame_pkg::RX_LEN) begin
                        shift_ff <= {shift_ff[143:0], orig};
                        cnt_ff <= cnt_ff + 5'h01;
                        if (cnt_ff < frame_pkg::BODY_LEN) begin
                            crc_ff <= frame_pkg::crc_step(crc_ff, orig);
                        end
                    end else begin
                        cnt_ff <= frame_pkg::RX_OVER;
                    end
                end
            end
        end
    end

    // ==========================================================
    // Result registers, updated only by good packets
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_ff <= 16'h0000;
            dst_ff <= 16'h0000;
            dist_ff <= 32'h0000_0000;
            vel_ff <= 32'h0000_0000;
            misc_ff <= 32'h0000_0000;
        end else if (clk_en && ev[frame_pkg::EV_OK]) begin
            src_ff <= shift_ff[frame_pkg::F_SRC +: 16];
            dst_ff <= shift_ff[frame_pkg::F_DST +: 16];
            dist_ff <= shift_ff[frame_pkg::F_DIST +: 32];
            vel_ff <= shift_ff[frame_pkg::F_VEL +: 32];
            misc_ff <= {shift_ff[frame_pkg::F_ANT +: 8], shift_ff[frame_pkg::F_LVL +: 8],
                        shift_ff[frame_pkg::F_ERR +: 8], shift_ff[frame_pkg::F_STAT +: 8]};
        end
    end

    // ==========================================================
    // APB slave
    assign apb_setup = psel && !penable;
    assign apb_wr = clk_en && psel && penable && pready_ff && pwrite;

    always_comb begin
        rd_hit = 1'b1;
        case (paddr)
            frame_pkg::OFS_CTRL: rd_mux = ctrl_ff;
            frame_pkg::OFS_STAT: rd_mux = {27'h000_0000, stat_ff};
            frame_pkg::OFS_MASK: rd_mux = {27'h000_0000, mask_ff};
            frame_pkg::OFS_SRC: rd_mux = {16'h0000, src_ff};
            frame_pkg::OFS_DST: rd_mux = {16'h0000, dst_ff};
            frame_pkg::OFS_DIST: rd_mux = dist_ff;
            frame_pkg::OFS_VEL: rd_mux = vel_ff;
            frame_pkg::OFS_MISC: rd_mux = misc_ff;
            frame_pkg::OFS_LEVEL: rd_mux = {{24{misc_ff[23]}}, misc_ff[23:16]};
            frame_pkg::OFS_ADDR_INFO: rd_mux = {dst_ff[0], dst_ff[10:1], dst_ff[15:11],
                                                src_ff[0], src_ff[10:1], src_ff[15:11]};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (clk_en) begin
            pready_ff <= apb_setup;
            if (apb_setup) begin
                prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_ff <= !rd_hit;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= frame_pkg::CTRL_RESET;
            mask_ff <= frame_pkg::MASK_RESET;
        end else if (apb_wr && paddr == frame_pkg::OFS_CTRL) begin
            ctrl_ff <= {31'h0000_0000, pwdata[0]};
        end else if (apb_wr && paddr == frame_pkg::OFS_MASK) begin
            mask_ff <= pwdata[4:0];
        end
    end

    // ==========================================================
    // Interrupt status, set wins over clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_ff <= 5'h00;
            irq_ff <= 1'b0;
            rdy_ff <= 1'b0;
        end else if (clk_en) begin
            stat_ff <= (stat_ff & ~((apb_wr && paddr == frame_pkg::OFS_STAT) ? pwdata[4:0]
                                                                              : 5'h00)) | ev;
            irq_ff <= |(stat_ff & mask_ff);
            rdy_ff <= ctrl_ff[0];
        end
    end

endmodule // distance_report_receiver

// file: test/distance_report_checker.sv
// Purpose: Link checks between framer and receiver
// Assumes: One clock, rst_n async active low
// Notes: Sees only the shared byte link
`timescale 1ns/100ps
module distance_report_checker (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [7:0] data,
    input wire logic valid,
    input wire logic ready
);
    // ==========================================================
    // Frame tracking
    logic take;
    logic in_frame_ff;
    logic [4:0] cnt_ff;
    assign take = valid & ready & clk_en;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_frame_ff <= 1'b0;
            cnt_ff <= 5'h00;
        end else if (take) begin
            in_frame_ff <= (data != 8'h7F);
            if (data == 8'h7E) begin
                cnt_ff <= 5'h01;
            end else if (data != 8'h7D) begin
                cnt_ff <= cnt_ff + 5'h01;
            end
        end
    end
    // ==========================================================
    // Link properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_start_then_type: assert property (take && data == 8'h7E |=> data == 8'h00)
        else $error("type byte wrong");
    a_end_then_idle: assert property (take && data == 8'h7F |=> !valid)
        else $error("valid after end");
    a_rise_on_start: assert property ($rose(valid) |-> data == 8'h7E)
        else $error("frame opens without start");
    a_valid_held: assert property (valid && !(take && data == 8'h7F) |=> valid)
        else $error("valid dropped in frame");
    a_data_held: assert property (valid && !take |=> $stable(data))
        else $error("data changed unaccepted");
    a_escape_pair: assert property (take && in_frame_ff && data == 8'h7D
        |=> data inside {8'h5D, 8'h5E, 8'h5F})
        else $error("bad escaped byte");
    a_no_bare_start: assert property (valid && in_frame_ff |-> data != 8'h7E)
        else $error("start inside frame");
    a_unstuffed_len: assert property (take && data == 8'h7F |-> cnt_ff == 5'h14)
        else $error("unstuffed length wrong");
endmodule // distance_report_checker

// file: test/distance_report_framer_tb_top.sv
// Purpose: Bench for framer and receiver joined by the link
// Assumes: ref_clk 200 MHz, rst_n async active low
// Notes: Seeded random reports plus corner cases
`timescale 1ns/100ps
module distance_report_framer_tb_top;
    localparam logic [31:0] MAXR = frame_pkg::RANGE_120M_MM;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic req_valid = 1'b0;
    logic [116:0] v = '0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mask_on, er, req_ready, pready, pslverr, irq;
    logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
    logic [4:0] own_station, peer_station;
    logic [9:0] own_group, peer_group;
    logic [3:0] base_port, peer_port;
    logic signed [31:0] distance, velocity;
    logic [7:0] level;
    logic [6:0] fault;
    logic [7:0] got[$], exq[$];
    logic [127:0] r;
    int miscompares = 0, comparisons = 0, seed = 32'hea89;
    assign {own_station, own_group, peer_station, peer_group, base_port, peer_port, distance,
        velocity, level, fault} = v;
    frame_link_if i_frame_link_if();
    distance_report_framer #(.MAX_RANGE_MM(MAXR)) i_distance_report_framer (.ref_clk, .rst_n,
        .clk_en, .req_valid, .req_ready, .own_station, .own_group, .peer_station, .peer_group,
        .base_port, .peer_port, .distance, .velocity, .level, .fault, .link(i_frame_link_if));
    distance_report_receiver i_distance_report_receiver (.ref_clk, .rst_n, .clk_en, .paddr,
        .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq,
        .link(i_frame_link_if));
    distance_report_checker i_distance_report_checker (.ref_clk, .rst_n, .clk_en,
        .data(i_frame_link_if.data), .valid(i_frame_link_if.valid),
        .ready(i_frame_link_if.ready));
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (i_frame_link_if.valid & i_frame_link_if.ready & clk_en) begin
            got.push_back(i_frame_link_if.data);
        end
    end
    task automatic tally_and_finish();
        if (miscompares == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wait_hi(input bit apb_side);
        int t;
        t = 0;
        do begin
            @(posedge ref_clk);
            t++;
        end while ((apb_side ? pready : req_ready) !== 1'b1 && t < 300);
        if ((apb_side ? pready : req_ready) !== 1'b1) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
            tally_and_finish();
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge ref_clk);
        penable <= 1'b1;
        wait_hi(1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic send();
        got.delete();
        req_valid <= 1'b1;
        wait_hi(1'b0);
        req_valid <= 1'b0;
        @(posedge ref_clk);
        wait_hi(1'b0);
    endtask
    task automatic stall();
        repeat (6) @(posedge ref_clk);
        clk_en <= 1'b0;
        repeat (3) @(posedge ref_clk);
        clk_en <= 1'b1;
        apb(1'b1, frame_pkg::OFS_CTRL, 32'h0000_0000);
        repeat (8) @(posedge ref_clk);
        apb(1'b1, frame_pkg::OFS_CTRL, 32'h0000_0001);
    endtask
    task automatic check_pkt();
        logic [135:0] b;
        logic [31:0] d, ex[6];
        logic [7:0] of[6], e, x;
        logic [15:0] c;
        logic st;
        st = distance > $signed(MAXR);
        d = st ? MAXR : distance;
        e = 8'h00;
        for (int k = 6; k >= 0; k--) begin
            if (fault[k]) begin
                e = 8'(k + 1);
            end
        end
        b = {8'h00, own_station, own_group, 1'b1, peer_station, peer_group, 1'b0, base_port,
            peer_port, d, velocity, level, e, 7'h00, st};
        c = 16'h0000;
        exq = {8'h7E};
        for (int i = 0; i < 19; i++) begin
            x = (i < 17) ? b[135 - 8 * i -: 8] : ((i == 17) ? c[15:8] : c[7:0]);
            if (i < 17) begin
                c = c ^ {8'h00, x};
                for (int j = 0; j < 8; j++) begin
                    c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
                end
            end
            if (x >= 8'h7D && x <= 8'h7F) begin
                exq.push_back(8'h7D);
                x = x ^ 8'h20;
            end
            exq.push_back(x);
        end
        exq.push_back(8'h7F);
        chk(32'(got.size()), 32'(exq.size()));
        foreach (exq[i]) begin
            chk({24'h0, got[i]}, {24'h0, exq[i]});
        end
        repeat (4) @(posedge ref_clk);
        of = '{frame_pkg::OFS_STAT, frame_pkg::OFS_DIST, frame_pkg::OFS_MISC,
            frame_pkg::OFS_LEVEL, frame_pkg::OFS_ADDR_INFO, frame_pkg::OFS_VEL};
        ex = '{{27'h0, e != 8'h00, 4'h1}, d, {base_port, peer_port, level, e, 7'h00, st},
            {{24{level[7]}}, level}, {1'b0, peer_group, peer_station, 1'b1, own_group, own_station},
            velocity};
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, of[i], 32'h0000_0000);
            chk(rd, ex[i]);
        end
        chk({31'h0, irq}, {31'h0, mask_on});
        apb(1'b1, frame_pkg::OFS_STAT, 32'h0000_001F);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0000_0000);
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0001);
        apb(1'b0, frame_pkg::OFS_CTRL, 32'h0000_0000);
        chk(rd, frame_pkg::CTRL_RESET);
        for (int n = 0; n < 14; n++) begin
            mask_on = n[0];
            apb(1'b1, frame_pkg::OFS_MASK, {31'h0, mask_on});
            r = {$random(seed), $random(seed), $random(seed), $random(seed)};
            case (n)
                0: r[116:0] = {5'h01, 10'h001, 5'h01, 10'h001, 4'h1, 4'h1, 32'h0000_1062,
                    32'h0000_007A, 8'hE6, 7'h00};
                1: r[78:0] = {MAXR, 32'h7D7E_7F5D, 8'h7F, 7'h00};
                2: r[78:47] = MAXR + 32'h0000_0001;
                3: r[78:47] = 32'h8000_0000;
                default: r[6:0] = (n < 11) ? 7'(1 << (n - 4)) : r[6:0];
            endcase
            v <= r[116:0];
            @(posedge ref_clk);
            if (n == 2) begin
                fork
                    send();
                    stall();
                join
            end else begin
                send();
            end
            check_pkt();
            if (n == 0) begin
                chk({got[2], got[3], got[18], got[19]}, 32'h0803_AFC4);
            end
        end
        tally_and_finish();
    end
endmodule // distance_report_framer_tb_top
